// File: rtl/bovx_exec.sv
// module: branch-on-overflow decoder and program counter update
`timescale 1ns/100ps
// Function
// - branch only when overflow flag is one
// - sign-extend offset, double, add to pc
// - target is instruction address plus 2 plus 2n
// - opcode upper byte 1110 0100, low byte offset
// - one cycle not taken, two when taken
// - decode, read literal, process, write pc in q4
module bovx_exec
  import bovx_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [bovx_pkg::BOVX_IW_W-1:0] instr_in,
  input wire logic signed_overflow_flag_in,
  output logic [bovx_pkg::BOVX_PC_W-1:0] pc_out,
  output logic [1:0] qphase_out,
  output logic branch_if_ovf_flag_op_out,
  output logic branch_taken_out,
  output logic flush_out,
  output logic exec_en_out
);
  import bovx_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_b_r;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // phase sequencer
  // ----------------------------------------
  logic [1:0] q_r, q_nxt;
  bovx_state_e st_r, st_nxt;
  logic [BOVX_PC_W-1:0] pc_r, pc_nxt;
  logic [BOVX_PC_W-1:0] iaddr_r, iaddr_nxt;
  logic is_bov_r, is_bov_nxt;
  logic [7:0] lit_r, lit_nxt;
  logic take_r, take_nxt;
  logic [BOVX_PC_W-1:0] tgt_r, tgt_nxt;
  logic taken_out_r, taken_out_nxt;
  wire [BOVX_PC_W-1:0] ofs2;

  // the phases run freely; a taken branch just spends one more lap
  always_comb begin
    q_nxt = q_r + 2'h1;
  end

  always_ff @(posedge mclk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      q_r <= BOVX_Q1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // execute state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    take_nxt = take_r;
    unique case (st_r)
      BOVX_EXEC: begin
        if (q_r == BOVX_Q3) begin
          take_nxt = is_bov_r && signed_overflow_flag_in;
        end
        if (q_r == BOVX_Q4 && take_r) begin
          st_nxt = BOVX_FLUSH;
        end
      end
      BOVX_FLUSH: begin
        // forced no-op cycle while the prefetch refills
        if (q_r == BOVX_Q4) begin
          st_nxt = BOVX_EXEC;
          take_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      st_r <= BOVX_EXEC;
      take_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      take_r <= take_nxt;
    end
  end

  // ----------------------------------------
  // decode and literal capture
  // ----------------------------------------
  // opcode and literal are caught only in a live cycle, so a word that
  // shows up during the flush never reaches the decoder
  always_comb begin
    is_bov_nxt = is_bov_r;
    lit_nxt = lit_r;
    if (st_r == BOVX_EXEC && q_r == BOVX_Q1) begin
      is_bov_nxt = (instr_in[15:8] == BOVX_OPC_BRANCH_OVF);
    end
    if (st_r == BOVX_EXEC && q_r == BOVX_Q2) begin
      lit_nxt = instr_in[7:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      is_bov_r <= 1'b0;
      lit_r <= 8'h00;
    end else begin
      is_bov_r <= is_bov_nxt;
      lit_r <= lit_nxt;
    end
  end

  // ----------------------------------------
  // offset extension and branch target
  // ----------------------------------------
  // bit 0 stays clear because the offset counts words, not bytes
  assign ofs2[0] = 1'b0;
  assign ofs2[8:1] = lit_r;
  for (genvar gi = 9; gi < BOVX_PC_W; gi++) begin : g_sext
    assign ofs2[gi] = lit_r[7];
  end

  // formed in q3 so the q4 write is a plain load with no adder behind it
  always_comb begin
    tgt_nxt = tgt_r;
    if (st_r == BOVX_EXEC && q_r == BOVX_Q3) begin
      tgt_nxt = iaddr_r + BOVX_PC_STEP + ofs2;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      tgt_r <= BOVX_PC_RST;
    end else begin
      tgt_r <= tgt_nxt;
    end
  end

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  // pc already points past the executing word once q1 ends
  always_comb begin
    pc_nxt = pc_r;
    iaddr_nxt = iaddr_r;
    taken_out_nxt = taken_out_r;
    unique case (st_r)
      BOVX_EXEC: begin
        if (q_r == BOVX_Q1) begin
          iaddr_nxt = pc_r;
          pc_nxt = pc_r + BOVX_PC_STEP;
          taken_out_nxt = 1'b0;
        end
        if (q_r == BOVX_Q4 && take_r) begin
          pc_nxt = tgt_r;
          taken_out_nxt = 1'b1;
        end
      end
      BOVX_FLUSH: begin
        // pc holds: the flushed word must not advance it
        if (q_r == BOVX_Q4) begin
          taken_out_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      pc_r <= BOVX_PC_RST;
      iaddr_r <= BOVX_PC_RST;
      taken_out_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      iaddr_r <= iaddr_nxt;
      taken_out_r <= taken_out_nxt;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  logic flush_r, flush_nxt;
  logic exec_r, exec_nxt;
  logic dec_r, dec_nxt;
  logic [1:0] qo_r;
  logic [BOVX_PC_W-1:0] pco_r;

  always_comb begin
    // outputs describe the phase that starts at this edge
    flush_nxt = (st_nxt == BOVX_FLUSH);
    exec_nxt = (st_nxt == BOVX_EXEC);
    dec_nxt = (st_nxt == BOVX_EXEC) ? is_bov_nxt : 1'b0;
  end

  always_ff @(posedge mclk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      flush_r <= 1'b0;
      exec_r <= 1'b0;
      dec_r <= 1'b0;
      qo_r <= BOVX_Q1;
      pco_r <= BOVX_PC_RST;
    end else begin
      flush_r <= flush_nxt;
      exec_r <= exec_nxt;
      dec_r <= dec_nxt;
      qo_r <= q_nxt;
      pco_r <= pc_nxt;
    end
  end

  assign pc_out = pco_r;
  assign qphase_out = qo_r;
  assign branch_if_ovf_flag_op_out = dec_r;
  assign branch_taken_out = taken_out_r;
  assign flush_out = flush_r;
  assign exec_en_out = exec_r;
endmodule

// File: rtl/bovx_pkg.sv
// package: constants for the branch-on-overflow decode and execute block
package bovx_pkg;
  localparam int BOVX_PC_W = 21;
  localparam int BOVX_IW_W = 16;
  localparam logic [7:0] BOVX_OPC_BRANCH_OVF = 8'hE4;
  localparam logic [20:0] BOVX_PC_RST = 21'h000000;
  localparam logic [20:0] BOVX_PC_STEP = 21'h000002;
  localparam logic [1:0] BOVX_Q1 = 2'h0;
  localparam logic [1:0] BOVX_Q2 = 2'h1;
  localparam logic [1:0] BOVX_Q3 = 2'h2;
  localparam logic [1:0] BOVX_Q4 = 2'h3;
  typedef enum logic [0:0] {BOVX_EXEC, BOVX_FLUSH} bovx_state_e;
endpackage

// File: testbench/bovx_exec_checker.sv
// checker for the branch-on-overflow block
`timescale 1ns/100ps
module bovx_chk (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [15:0] instr_in,
  input wire logic signed_overflow_flag_in,
  input wire logic [20:0] pc_out,
  input wire logic [1:0] qphase_out,
  input wire logic branch_if_ovf_flag_op_out,
  input wire logic flush_out,
  input wire logic exec_en_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  wire t3 = qphase_out == 2'h2 && branch_if_ovf_flag_op_out;
  wire v = signed_overflow_flag_in;
  property p_dec; qphase_out == 2'h0 && !flush_out &&
    instr_in[15:8] == 8'hE4 |=> branch_if_ovf_flag_op_out; endproperty
  a_dec: assert property (p_dec) else $error("decode");
  property p_tk; t3 |-> ##2 flush_out == $past(v, 2); endproperty
  a_tk: assert property (p_tk) else $error("take");
  property p_tgt; t3 && v |-> ##2 pc_out == $past(pc_out) +
    {{12{$past(instr_in[7], 2)}}, $past(instr_in[7:0], 2), 1'b0};
  endproperty
  a_tgt: assert property (p_tgt) else $error("target");
  property p_fl; $rose(flush_out) |-> flush_out[*4] ##1 !flush_out;
  endproperty
  a_fl: assert property (p_fl) else $error("flush");
  property p_ex; flush_out && $past(flush_out) |->
    $stable(pc_out) && !exec_en_out; endproperty
  a_ex: assert property (p_ex) else $error("discard");
  property p_inc; qphase_out == 2'h1 && exec_en_out |->
    pc_out == $past(pc_out) + 21'h2; endproperty
  a_inc: assert property (p_inc) else $error("step");
  property p_nt; t3 && !v |-> ##2 pc_out == $past(pc_out, 2);
  endproperty
  a_nt: assert property (p_nt) else $error("no jump");
endmodule
bind bovx_exec bovx_chk i_chk (.mclk_in, .rst_b_in, .instr_in,
  .signed_overflow_flag_in, .pc_out, .qphase_out,
  .branch_if_ovf_flag_op_out, .flush_out, .exec_en_out);

// File: testbench/tb_bovx_exec.sv
// testbench for the branch-on-overflow block
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH %0t value", $time); end end
module tb_bovx_exec;
  import bovx_pkg::*;
  logic mclk_in = 0, rst_b_in = 0, ovf = 0, op, tk, fl, en;
  logic [15:0] instr = 16'h0000;
  logic [20:0] pc, a, e;
  logic [1:0] qp;
  int bad_count = 0, checks_done = 0, k;
  always #5 mclk_in = ~mclk_in;
  bovx_exec i_bovx_exec (.mclk_in, .rst_b_in, .instr_in(instr),
    .signed_overflow_flag_in(ovf), .pc_out(pc), .qphase_out(qp),
    .branch_if_ovf_flag_op_out(op), .branch_taken_out(tk),
    .flush_out(fl), .exec_en_out(en));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(input logic [15:0] w, input logic v, input logic t);
    for (k = 0; k < 8 && !(qp === 2'h0 && fl === 1'b0); k++)
      @(negedge mclk_in);
    `CHK(qp, 2'h0)
    a = pc;
    instr = w;
    ovf = v;
    e = t ? a + 21'h2 + {{12{w[7]}}, w[7:0], 1'b0} : a + 21'h2;
    @(negedge mclk_in);
    `CHK(op, w[15:8] == 8'hE4)
    repeat (3) @(negedge mclk_in);
    `CHK(fl, t)
    `CHK(tk, t)
    `CHK(pc, e)
    `CHK(en, !t)
    if (t) begin
      // a live opcode and flag during the flush must be ignored
      instr = 16'hE401;
      repeat (3) @(negedge mclk_in);
      `CHK(en, 1'b0)
      `CHK(pc, e)
      @(negedge mclk_in);
      `CHK(fl, 1'b0)
      `CHK(tk, 1'b0)
      `CHK(en, 1'b1)
    end
    $display("test %h done", w);
  endtask
  task automatic t_neg(); run(16'hE480, 1'b1, 1'b1); endtask
  task automatic t_pos(); run(16'hE47F, 1'b1, 1'b1); endtask
  task automatic t_off(); run(16'hE47F, 1'b0, 1'b0); endtask
  task automatic t_opc(); run(16'hE07F, 1'b1, 1'b0); endtask
  initial begin
    repeat (16) @(negedge mclk_in);
    rst_b_in = 1;
    for (k = 0; k < 9 && qp !== 2'h1; k++) @(negedge mclk_in);
    `CHK(qp, 2'h1)
    t_neg();
    t_pos();
    t_off();
    t_opc();
    t_neg();
    conclude();
  end
  // about 55 cycles expected; generous margin before calling it a hang
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
endmodule
